// ### ccm_defines.vh
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH

// ****************************************
// register offsets on the byte port
// ****************************************
`define CCM_ADDR_MODE      3'h0
`define CCM_ADDR_PWMCFG    3'h1
`define CCM_ADDR_VAL_LO    3'h2
`define CCM_ADDR_VAL_HI    3'h3
`define CCM_ADDR_STATUS    3'h4
`define CCM_ADDR_MASK      3'h5
`define CCM_ADDR_PIN       3'h6

// ****************************************
// channel_mode_reg fields
// ****************************************
`define CCM_MODE_IRQ_EN    0
`define CCM_MODE_PWM_SEL   1
`define CCM_MODE_TOGGLE    2
`define CCM_MODE_MATCH     3
`define CCM_MODE_FALL      4
`define CCM_MODE_RISE      5
`define CCM_MODE_CMP_EN    6
`define CCM_MODE_PWM16     7

// ****************************************
// pwm_config_reg fields
// ****************************************
`define CCM_PWM_RELOAD_SEL 7
`define CCM_PWM_OVF_IEN    5
`define CCM_PWM_CLS_HI     1
`define CCM_PWM_CLS_LO     0

// ****************************************
// status and mask bits
// ****************************************
`define CCM_ST_EVENT       0
`define CCM_ST_OVF         1

// ****************************************
// reset values
// ****************************************
`define CCM_RST_BYTE       8'h00
`define CCM_RST_STATUS     2'h0
`define CCM_RST_MASK       2'h3

`endif

// ### ccm_pin_sync.v
// ****************************************
// pin synchroniser and edge detector
// ****************************************
module ccm_pin_sync (
	input  wire mclk,
	input  wire resetn,
	input  wire pin_i,
	output reg  level_r,
	output reg  rise_r,
	output reg  fall_r
);

	reg sync1_r;
	reg sync2_r;
	reg prev_r;

	// two stages before any logic looks at the pin
	always @(posedge mclk) begin
		if (!resetn) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
			level_r <= 1'b0;
			rise_r  <= 1'b0;
			fall_r  <= 1'b0;
		end else begin
			sync1_r <= pin_i;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
			level_r <= sync2_r;
			rise_r  <= sync2_r & ~prev_r;
			fall_r  <= ~sync2_r & prev_r;
		end
	end

endmodule // ccm_pin_sync

// ### ccm_channel.v
// What this block does
// - each channel runs one of six modes from its mode and its own config.
// - mode bits 5:4 pick rising, falling or both capture edges.
// - bits 3:1 pick software timer, high-speed output or frequency output.
// - bit1 alone gives 8..11 bit pwm, config bits 1:0 pick length.
// - bits 7 and 1 together give 16 bit pwm.
// - each channel keeps its own short pwm cycle length in its own config register.
// - interrupt raised while event flag, mode bit 0 and mask bit 0 are set.
// - config bit 5 enables the short pwm overflow interrupt.
// - mode bit 6 clear stops the comparator; pwm output stays low.
// - config bit 7 routes value bytes to reload register in 9..11 bit pwm.
// - a match sets the event flag when mode bit 3 is set.
// - a capture copies the whole 16 bit counter into the value register.
// - every capture sets the event flag.
// - the flag stays set until software clears it.
// - pin level stays readable when both edges capture.
`include "ccm_defines.vh"

module ccm_channel (
	input  wire        mclk,
	input  wire        resetn,
	input  wire [2:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata_r,
	input  wire [15:0] cnt_value,
	input  wire        channel_pin_i,
	output reg         channel_pin_o_r,
	output reg         channel_pin_oe_r,
	output reg         irq_r
);

	// ****************************************
	// registers
	// ****************************************
	reg  [7:0]  channel_mode_reg_r;
	reg  [7:0]  pwm_config_reg_r;
	reg  [7:0]  val_lo_r;
	reg  [7:0]  val_hi_r;
	reg  [7:0]  reload_lo_r;
	reg  [7:0]  reload_hi_r;
	reg  [1:0]  status_r;
	reg  [1:0]  mask_r;
	reg  [15:0] cnt_prev_r;
	reg         pin_state_r;

	wire        pin_level;
	wire        pin_rise;
	wire        pin_fall;

	// ****************************************
	// pin input
	// ****************************************
	// the pin is foreign to mclk; the driver is expected to hold each
	// level for two clocks, shorter glitches can vanish here
	ccm_pin_sync u_sync (
		.mclk    (mclk),
		.resetn  (resetn),
		.pin_i   (channel_pin_i),
		.level_r (pin_level),
		.rise_r  (pin_rise),
		.fall_r  (pin_fall)
	);

	// ****************************************
	// mode decode
	// ****************************************
	wire [7:0] md = channel_mode_reg_r;
	wire       cmp_on = md[`CCM_MODE_CMP_EN];

	// capture: bits 3:1 zero, at least one edge enabled
	wire mode_cap = (md[3:1] == 3'b000) &
		(md[`CCM_MODE_RISE] | md[`CCM_MODE_FALL]);

	// the three match modes share bits 5:4 clear
	wire m54_clr = ~md[`CCM_MODE_RISE] & ~md[`CCM_MODE_FALL];
	wire mode_swt = m54_clr & (md[3:1] == 3'b100);
	wire mode_hso = m54_clr & (md[3:1] == 3'b110);
	wire mode_frq = m54_clr & (md[3:1] == 3'b011);

	// pwm: bit 1 set with bits 5,4,2 clear; bit 7 chooses 16 bit
	wire pwm_any = m54_clr & ~md[`CCM_MODE_TOGGLE] & md[`CCM_MODE_PWM_SEL];
	wire mode_p16 = pwm_any & md[`CCM_MODE_PWM16];
	wire mode_pn = pwm_any & ~md[`CCM_MODE_PWM16];

	// one length field per channel, so each short pwm channel sets its own
	wire [1:0] cls = pwm_config_reg_r[`CCM_PWM_CLS_HI:`CCM_PWM_CLS_LO];

	// ****************************************
	// short pwm length mask
	// ****************************************
	reg [10:0] len_mask;

	// 00 is 8 bits up to 11 is 11 bits
	always @* begin
		case (cls)
			2'b00:   len_mask = 11'h0FF;
			2'b01:   len_mask = 11'h1FF;
			2'b10:   len_mask = 11'h3FF;
			default: len_mask = 11'h7FF;
		endcase
	end

	wire [10:0] cnt_n  = cnt_value[10:0] & len_mask;
	wire [10:0] prev_n = cnt_prev_r[10:0] & len_mask;
	wire [10:0] val_n  = {val_hi_r[2:0], val_lo_r} & len_mask;

	// wrap of the low n bits marks the end of a short pwm cycle
	wire ovf_n = (prev_n == len_mask) & (cnt_n == 11'h000) &
		(cnt_value != cnt_prev_r);

	// 9..11 bit pwm with select set steers byte access to reload
	wire long_n = mode_pn & (cls != 2'b00);
	wire to_reload = long_n & pwm_config_reg_r[`CCM_PWM_RELOAD_SEL];

	// ****************************************
	// comparator
	// ****************************************
	wire [15:0] val16 = {val_hi_r, val_lo_r};
	wire        eq16 = (cnt_value == val16);
	wire        eq8  = (cnt_value[7:0] == val_lo_r);
	wire        eqn  = (cnt_n == val_n);

	// counter changes are the only moments a match may fire, so a
	// stalled counter does not keep flagging the same value
	wire cnt_moved = (cnt_value != cnt_prev_r);

	// frequency output compares the low byte only, short pwm the low
	// n bits, everything else the whole 16 bit value
	reg eq_sel;

	always @* begin
		if (mode_frq) begin
			eq_sel = eq8;
		end else if (mode_pn) begin
			eq_sel = eqn;
		end else begin
			eq_sel = eq16;
		end
	end

	// equality every clock gives a single cycle event
	wire match = cmp_on & cnt_moved & eq_sel &
		(mode_swt | mode_hso | mode_frq | pwm_any);

	// ****************************************
	// capture qualification
	// ****************************************
	wire cap_evt = mode_cap &
		((pin_rise & md[`CCM_MODE_RISE]) |
		 (pin_fall & md[`CCM_MODE_FALL]));

	// ****************************************
	// bus decode
	// ****************************************
	// a strobe hits one register at most; address 7 is not decoded
	wire wr_mode = reg_wr & (reg_addr == `CCM_ADDR_MODE);
	wire wr_pcfg = reg_wr & (reg_addr == `CCM_ADDR_PWMCFG);
	wire wr_lo   = reg_wr & (reg_addr == `CCM_ADDR_VAL_LO);
	wire wr_hi   = reg_wr & (reg_addr == `CCM_ADDR_VAL_HI);
	wire wr_st   = reg_wr & (reg_addr == `CCM_ADDR_STATUS);
	wire wr_mask = reg_wr & (reg_addr == `CCM_ADDR_MASK);

	// ****************************************
	// configuration registers
	// ****************************************
	always @(posedge mclk) begin
		if (!resetn) begin
			channel_mode_reg_r <= `CCM_RST_BYTE;
			pwm_config_reg_r   <= `CCM_RST_BYTE;
			mask_r             <= `CCM_RST_MASK;
		end else begin
			if (wr_mode) begin
				channel_mode_reg_r <= reg_wdata;
			end
			if (wr_pcfg) begin
				pwm_config_reg_r <= reg_wdata;
			end
			if (wr_mask) begin
				mask_r <= reg_wdata[1:0];
			end
		end
	end

	// ****************************************
	// frequency step
	// ****************************************
	// the sum is cut to a byte on purpose: the next toggle point wraps
	// around the low byte just as the low byte of the counter does
	wire [8:0] frq_sum  = {1'b0, val_lo_r} + {1'b0, val_hi_r};
	wire [7:0] frq_next = frq_sum[7:0];

	// ****************************************
	// value and reload registers
	// ****************************************
	// capture outranks a software write in the same cycle, since the
	// captured time cannot be recovered later
	always @(posedge mclk) begin
		if (!resetn) begin
			val_lo_r    <= `CCM_RST_BYTE;
			val_hi_r    <= `CCM_RST_BYTE;
			reload_lo_r <= `CCM_RST_BYTE;
			reload_hi_r <= `CCM_RST_BYTE;
		end else begin
			if (wr_lo & to_reload) begin
				reload_lo_r <= reg_wdata;
			end
			if (wr_hi & to_reload) begin
				reload_hi_r <= reg_wdata;
			end
			if (cap_evt) begin
				val_lo_r <= cnt_value[7:0];
				val_hi_r <= cnt_value[15:8];
			end else if (mode_frq & match) begin
				// next half period: step low byte by high byte
				val_lo_r <= frq_next;
			end else if (mode_pn & ovf_n & ~(cls == 2'b00)) begin
				// new duty takes effect only at a cycle boundary
				val_lo_r <= reload_lo_r;
				val_hi_r <= reload_hi_r;
			end else if (mode_pn & ovf_n) begin
				val_lo_r <= val_hi_r;
			end else begin
				if (wr_lo & ~to_reload) begin
					val_lo_r <= reg_wdata;
				end
				if (wr_hi & ~to_reload) begin
					val_hi_r <= reg_wdata;
				end
			end
		end
	end

	// ****************************************
	// sticky status
	// ****************************************
	wire [1:0] st_set;

	assign st_set[`CCM_ST_EVENT] = cap_evt | (match & md[`CCM_MODE_MATCH]);
	assign st_set[`CCM_ST_OVF]   = mode_pn & ovf_n;

	wire [1:0] st_clr = wr_st ? reg_wdata[1:0] : 2'b00;

	// set wins over a clear that lands in the same cycle; nothing
	// else clears, so servicing the interrupt leaves the flag up
	always @(posedge mclk) begin
		if (!resetn) begin
			status_r <= `CCM_RST_STATUS;
		end else begin
			status_r <= (status_r & ~st_clr) | st_set;
		end
	end

	// ****************************************
	// interrupt
	// ****************************************
	wire [1:0] src_en;

	assign src_en[`CCM_ST_EVENT] = md[`CCM_MODE_IRQ_EN];
	assign src_en[`CCM_ST_OVF]   = pwm_config_reg_r[`CCM_PWM_OVF_IEN];

	// a source reaches the pin only when its own enable and its mask
	// bit are both set; the status bit is kept either way, so software
	// can poll an event it chose not to be interrupted by
	wire irq_nxt = |(status_r & mask_r & src_en);

	always @(posedge mclk) begin
		if (!resetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ****************************************
	// pin output
	// ****************************************
	reg  pin_nxt;
	wire n_hi  = (cnt_n >= val_n);
	wire h16   = (cnt_value >= val16);

	// toggling modes keep their level; pwm derives it each clock
	always @* begin
		pin_nxt = channel_pin_o_r;
		if ((mode_hso | mode_frq) & match) begin
			pin_nxt = ~channel_pin_o_r;
		end else if (mode_pn) begin
			pin_nxt = cmp_on & n_hi;
		end else if (mode_p16) begin
			pin_nxt = cmp_on & h16;
		end
	end

	// capture and software timer leave the pin to the outside world;
	// every mode that owns a waveform drives it
	wire oe_nxt = mode_hso | mode_frq | pwm_any;

	always @(posedge mclk) begin
		if (!resetn) begin
			channel_pin_o_r  <= 1'b0;
			channel_pin_oe_r <= 1'b0;
			cnt_prev_r       <= 16'h0000;
			pin_state_r      <= 1'b0;
		end else begin
			channel_pin_o_r  <= pin_nxt;
			channel_pin_oe_r <= oe_nxt;
			cnt_prev_r       <= cnt_value;
			pin_state_r      <= pin_level;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	reg [7:0] rd_nxt;

	// unmapped addresses answer zero; the value bytes follow the same
	// routing as writes, so software reads back what it steered there
	always @* begin
		case (reg_addr)
			`CCM_ADDR_MODE:   rd_nxt = channel_mode_reg_r;
			`CCM_ADDR_PWMCFG: rd_nxt = pwm_config_reg_r;
			`CCM_ADDR_VAL_LO: rd_nxt = to_reload ? reload_lo_r : val_lo_r;
			`CCM_ADDR_VAL_HI: rd_nxt = to_reload ? reload_hi_r : val_hi_r;
			`CCM_ADDR_STATUS: rd_nxt = {6'h00, status_r};
			`CCM_ADDR_MASK:   rd_nxt = {6'h00, mask_r};
			`CCM_ADDR_PIN:    rd_nxt = {7'h00, pin_state_r};
			default:          rd_nxt = 8'h00;
		endcase
	end

	// data stand only in the cycle after the read strobe
	always @(posedge mclk) begin
		if (!resetn) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_r <= rd_nxt;
		end else begin
			reg_rdata_r <= 8'h00;
		end
	end

endmodule // ccm_channel

// ### ccm_channel_props.sv
`include "ccm_defines.vh"
// ****************
// channel checker
// ****************
module ccm_channel_props (
	input wire        mclk,
	input wire        resetn,
	input wire [2:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata_r,
	input wire [15:0] cnt_value,
	input wire        channel_pin_i,
	input wire        channel_pin_o_r,
	input wire        channel_pin_oe_r,
	input wire        irq_r
);
	timeunit 1ns;
	timeprecision 1ns;
	reg  [7:0]  mode_r;
	reg  [7:0]  cfg_r;
	reg  [1:0]  mask_r;
	reg  [15:0] val_r;
	// interrupt sources that can reach the output
	wire [1:0]  en_w = {cfg_r[5] & mask_r[1], mode_r[0] & mask_r[0]};
	// pwm with the comparator off; p16 skips reload routing so the mirror stays true
	wire        poff_w = mode_r[6:4] == 3'h0 && mode_r[2:1] == 2'h1;
	wire        p16_w = mode_r[7:4] == 4'hC && mode_r[2:1] == 2'h1 && !cfg_r[7];
	// mirror of what software wrote
	always @(posedge mclk) begin
		if (!resetn) begin
			mode_r <= 8'h00;
			cfg_r  <= 8'h00;
			mask_r <= 2'h3;
			val_r  <= 16'h0000;
		end else if (reg_wr) begin
			case (reg_addr)
				3'h0: mode_r <= reg_wdata;
				3'h1: cfg_r <= reg_wdata;
				3'h2: val_r[7:0] <= reg_wdata;
				3'h3: val_r[15:8] <= reg_wdata;
				3'h5: mask_r <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
		else $error("read data outside its cycle");
	a_mode_readback: assert property ($past(reg_rd) && $past(reg_addr) == 3'h0
		|-> reg_rdata_r == $past(mode_r)) else $error("mode readback wrong");
	// pin seen high, two sync stages, edge flop, status, then irq
	a_capture_irq: assert property ($rose(channel_pin_i) && mode_r == 8'h21 && mask_r[0]
		&& !reg_wr ##1 !reg_wr [*3] |-> ##2 irq_r) else $error("capture raised no interrupt");
	a_irq_gate: assert property (en_w == 2'h0 && $past(en_w) == 2'h0 |-> !irq_r)
		else $error("interrupt while disabled");
	a_oe_capture: assert property (mode_r[2:1] == 2'h0
		&& $past(mode_r[2:1]) == 2'h0 |-> !channel_pin_oe_r) else $error("pin driven");
	a_oe_pwm: assert property (mode_r[6:4] == 3'h4 && mode_r[2:1] == 2'h1
		&& $stable(mode_r) |-> channel_pin_oe_r) else $error("pwm pin not driven");
	a_pwm_off: assert property (poff_w && $past(poff_w) |-> !channel_pin_o_r)
		else $error("pwm output high with comparator off");
	a_pwm16_level: assert property (p16_w && $past(p16_w)
		|-> channel_pin_o_r == ($past(cnt_value) >= $past(val_r))) else $error("pwm16 level");
endmodule // ccm_channel_props

bind ccm_channel ccm_channel_props chk_u (
	.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .cnt_value(cnt_value),
	.channel_pin_i(channel_pin_i), .channel_pin_o_r(channel_pin_o_r),
	.channel_pin_oe_r(channel_pin_oe_r), .irq_r(irq_r)
);

// ### ccm_pin_src.sv
// ****************
// pin source
// ****************
module ccm_pin_src (
	input  wire  mclk,
	input  wire  want,
	input  wire  dut_oe,
	input  wire  dut_o,
	output logic pad
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       lvl_r = 1'b0;
	logic [1:0] held_r = 2'h0;
	// a new level waits until the old one has stood three clocks
	always @(posedge mclk) begin
		if (want != lvl_r && held_r[1]) begin
			lvl_r <= want;
			held_r <= 2'h0;
		end else if (!held_r[1]) begin
			held_r <= held_r + 2'h1;
		end
	end
	// the pad shows the channel's own level while it drives
	assign pad = dut_oe ? dut_o : lvl_r;
endmodule // ccm_pin_src

// ### ccm_channel_tb.sv
// ****************
// channel testbench
// ****************
module ccm_channel_tb;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
		$display("unexpected %s expected %h seen %h", n, e, g); end end
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] cnt_value = 16'h0000;
	logic        want = 1'b0;
	logic        p;
	wire  [7:0]  rdata;
	wire         pad;
	wire         pin_o;
	wire         oe;
	wire         irq;
	int          mismatches = 0;
	int          check_count = 0;
	always #5 mclk = ~mclk;
	ccm_channel dut_u (
		.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata), .cnt_value(cnt_value),
		.channel_pin_i(pad), .channel_pin_o_r(pin_o), .channel_pin_oe_r(oe), .irq_r(irq)
	);
	ccm_pin_src src_u (.mclk(mclk), .want(want), .dut_oe(oe), .dut_o(pin_o), .pad(pad));
	// bus cycles: one strobe cycle each, read data one cycle later
	task automatic wr(input [2:0] a, input [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input [2:0] a, input [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 `CHK("rdata", e, rdata)
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// counter steps once a clock so every value raises a fresh compare
	task automatic run(input [15:0] s, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			cnt_value <= s + 16'(i);
		end
	endtask
	task automatic t_regs;
		for (int a = 0; a < 8; a++) rdc(3'(a), a == 5 ? 8'h03 : 8'h00);
		wr(3'h7, 8'hFF);
		rdc(3'h7, 8'h00);
		wr(3'h0, 8'hA5);
		rdc(3'h0, 8'hA5);
	endtask
	task automatic t_capture;
		logic [7:0] m [3] = '{8'h21, 8'h11, 8'h31};
		for (int i = 0; i < 3; i++) begin
			wr(3'h0, m[i]);
			cnt_value <= 16'h1200 + 16'(i);
			want <= 1'b1;
			idle(6);
			rdc(3'h4, {7'h0, m[i][5]});
			`CHK("irq", m[i][5], irq)
			rdc(3'h6, 8'h01);
			wr(3'h4, 8'h01);
			cnt_value <= 16'h3400 + 16'(i);
			want <= 1'b0;
			idle(6);
			rdc(3'h4, {7'h0, m[i][4]});
			rdc(3'h2, 8'(i));
			rdc(3'h3, m[i][4] ? 8'h34 : 8'h12);
			wr(3'h4, 8'h01);
		end
		want <= 1'b1;
		idle(6);
		wr(3'h5, 8'h00);
		idle(2);
		`CHK("irq", 1'b0, irq)
		wr(3'h5, 8'h03);
		idle(2);
		`CHK("irq", 1'b1, irq)
		wr(3'h4, 8'h01);
		idle(2);
		`CHK("irq", 1'b0, irq)
	endtask
	task automatic t_match;
		logic [7:0] m [5] = '{8'h49, 8'h41, 8'h4C, 8'h0C, 8'h46};
		for (int i = 0; i < 5; i++) begin
			wr(3'h2, 8'h40);
			wr(3'h3, 8'h00);
			wr(3'h0, m[i]);
			idle(2);
			p = pin_o;
			run(16'h0000, 'h50);
			idle(3);
			rdc(3'h4, {7'h0, m[i][3] & m[i][6]});
			`CHK("pin", p ^ (m[i][2] & m[i][6]), pin_o)
			`CHK("oe", m[i][2], oe)
			wr(3'h4, 8'h01);
		end
	endtask
	task automatic t_pwm;
		logic [15:0] c [3] = '{16'h00FF, 16'h0100, 16'hFFFF};
		wr(3'h0, 8'hC2);
		wr(3'h2, 8'h00);
		wr(3'h3, 8'h01);
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk);
			cnt_value <= c[i];
			idle(3);
			`CHK("pin", i != 0, pin_o)
		end
		wr(3'h0, 8'h82);
		idle(3);
		`CHK("pin", 1'b0, pin_o)
		for (int n = 0; n < 4; n++) begin
			wr(3'h1, (n != 0 ? 8'h20 : 8'h00) | 8'(n));
			wr(3'h0, 8'h42);
			run(16'(3 << (7 + n)) - 16'h4, 8);
			idle(2);
			rdc(3'h4, 8'h00);
			run(16'(1 << (8 + n)) - 16'h4, 8);
			idle(2);
			rdc(3'h4, 8'h02);
			`CHK("irq", n != 0, irq)
			wr(3'h4, 8'h03);
		end
		wr(3'h1, 8'h01);
		wr(3'h2, 8'h11);
		wr(3'h1, 8'h81);
		wr(3'h2, 8'h77);
		rdc(3'h2, 8'h77);
		wr(3'h1, 8'h01);
		rdc(3'h2, 8'h11);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// main sequence after eight clocks of reset
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		t_regs();
		t_capture();
		t_match();
		t_pwm();
		report_and_stop();
	end
	// the run needs under a thousand clocks; a hang is cut at twenty thousand
	initial begin
		#200000;
		mismatches++;
		report_and_stop();
	end
endmodule // ccm_channel_tb
